// file: ext_bus_params.svh
// timing counts, register offsets, fields and reset values of the bus unit
`ifndef EXT_BUS_PARAMS_SVH
`define EXT_BUS_PARAMS_SVH
`define CLK_PERIOD_NS 25
`define MC_CLKS 4
`define RESET_MC 2
`define RESET_CLKS (`RESET_MC * `MC_CLKS)
`define ADDR_CLKS 2
`define MIN_DATA_MC 2
`define CODE_INT_TOP 16'h8000
`define SRAM_TOP 16'h0400
`define REG_CTRL 4'h0
`define REG_STAT 4'h1
`define CTRL_STRETCH_LSB 0
`define CTRL_STRETCH_W 3
`define CTRL_WAIT_EN_BIT 3
`define CTRL_SRAM_ON_BIT 4
`define CTRL_RESET 8'h01
`define CTRL_MASK 8'h1f
`define P3_WR_BIT 6
`define P3_RD_BIT 7
`endif

// file: ext_bus_pkg.sv
// types shared by the external bus unit
package ext_bus_pkg;
   // kind of access the core asks for
   typedef enum logic [1:0] {
      ACC_FETCH = 2'h0,
      ACC_MOVC = 2'h1,
      ACC_DRD = 2'h2,
      ACC_DWR = 2'h3
   } acc_kind_t;
   // one core request
   typedef struct packed {
      acc_kind_t kind;
      logic [15:0] addr;
      logic [7:0] wdata;
   } acc_req_t;
   // sequencer states, gray along idle-addr-strobe
   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_ADDR = 2'h1,
      ST_STRB = 2'h3
   } seq_state_t;
   // alternate inputs fanned out from ports 1 and 3
   typedef struct packed {
      logic timer2_count_in;
      logic timer2_ctl_in;
      logic uart1_rx_pin;
      logic [3:0] ext_irq_hi;
      logic uart0_rx_pin;
      logic ext_irq0_pin;
      logic ext_irq1_pin;
      logic timer0_count_in;
      logic timer1_count_in;
   } alt_in_t;
endpackage : ext_bus_pkg

// file: ext_bus_unit.sv
// external memory bus sequencer and pin-function mux of the controller
//
// Operation
// - external-access low forces all fetches external
// - ea high, below 32 KB: fetch stays internal
// - program-store strobe on external fetch and movc
// - ale strobe lets latch capture low address
// - reset pin high two machine cycles resets
// - machine cycle is four clocks
// - port 0 open drain, else address/data
// - port 2 pulled up, else upper address
// - port 3 bits 6/7 write/read strobes
// - port 4 bit 0 optional wait input
// - port 1 alternate timer, uart, irq inputs
// - port 3 alternate uart, irq, timer functions
// - software sets data access length
// - data access two to nine machine cycles
// - on-chip sram off after reset
// - wait enabled makes port 4 bit 0 input
`timescale 1ns/1ps
`include "ext_bus_params.svh"
module ext_bus_unit
   import ext_bus_pkg::*;
(
   // clock, reset, enable
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic clk_en,
   // register port
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // core access port, hold valid until ack
   input wire logic req_valid,
   input wire acc_req_t req,
   output logic ack,
   output logic ack_local,
   output logic [7:0] ack_rdata,
   output logic busy,
   // core port latches and serial outputs
   input wire logic [7:0] p0_latch,
   input wire logic [7:0] p1_latch,
   input wire logic [7:0] p2_latch,
   input wire logic [7:0] p3_latch,
   input wire logic [3:0] p4_latch,
   input wire logic uart0_tx,
   input wire logic uart1_tx,
   // device reset out to the rest of the chip
   output logic core_rst,
   // control pins
   input wire logic ext_code_select_n,
   input wire logic rst_pin,
   output logic ale,
   output logic program_store_strobe_n,
   // port pins
   input wire logic [7:0] p0_in,
   output logic [7:0] p0_out,
   output logic [7:0] p0_oe,
   input wire logic [7:0] p1_in,
   output logic [7:0] p1_out,
   output logic [7:0] p1_oe,
   output logic [7:0] p2_out,
   output logic [7:0] p2_oe,
   input wire logic [7:0] p3_in,
   output logic [7:0] p3_out,
   output logic [7:0] p3_oe,
   input wire logic [3:0] p4_in,
   output logic [3:0] p4_out,
   output logic [3:0] p4_oe,
   // alternate pin inputs to timers, uarts, irq logic
   output alt_in_t alt_in
);

   // access is served on chip: internal rom or enabled sram
   function automatic logic is_local(input acc_req_t r, input logic ea_n,
                                     input logic sram_on);
      if (r.kind == ACC_FETCH || r.kind == ACC_MOVC) begin
         is_local = ea_n && (r.addr < `CODE_INT_TOP);
      end else begin
         is_local = sram_on && (r.addr < `SRAM_TOP);
      end
   endfunction : is_local

   // strobe clocks: code one half cycle, data stretch+2 cycles less addr
   function automatic logic [5:0] strb_clks(input acc_kind_t k,
                                            input logic [2:0] st);
      if (k == ACC_FETCH || k == ACC_MOVC) begin
         strb_clks = 6'(`MC_CLKS - `ADDR_CLKS);
      end else begin
         strb_clks = 6'((st + `MIN_DATA_MC) * `MC_CLKS - `ADDR_CLKS);
      end
   endfunction : strb_clks

   logic [1:0] phase_q; // clock within machine cycle
   logic [3:0] rst_cnt_q; // clocks seen with reset pin high
   logic core_rst_q; // device reset from the pin
   logic [7:0] ctrl_q; // stretch, wait enable, sram enable
   seq_state_t state_q; // bus sequencer state
   acc_req_t cur_q; // request being served
   logic [5:0] cnt_q; // clocks left in current state
   logic local_q; // last access stayed on chip
   logic [7:0] rdata_q;
   logic ack_q;
   logic ale_q;
   logic program_store_strobe_n_n_q;
   logic wr_n_q;
   logic rd_n_q;
   logic [7:0] p0_out_q, p0_oe_q, p1_out_q, p1_oe_q;
   logic [7:0] p2_out_q, p2_oe_q, p3_out_q, p3_oe_q;
   logic [3:0] p4_out_q, p4_oe_q;
   alt_in_t alt_q;
   logic mc_end; // last clock of a machine cycle
   logic soft_rst; // board reset or pin reset
   logic wait_en;
   logic wait_hold; // slow device asks for more time
   logic is_code;

   assign mc_end = (phase_q == 2'(`MC_CLKS - 1));
   assign soft_rst = !nrst || core_rst_q;
   assign wait_en = ctrl_q[`CTRL_WAIT_EN_BIT];
   assign wait_hold = wait_en && !p4_in[0];
   assign is_code = (cur_q.kind == ACC_FETCH) || (cur_q.kind == ACC_MOVC);

   // machine cycle phase, free running so bus timing stays aligned
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         phase_q <= 2'h0;
      end else if (clk_en) begin
         phase_q <= mc_end ? 2'h0 : phase_q + 2'h1;
      end
   end

   // reset pin filter: a glitch shorter than two cycles is ignored
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         rst_cnt_q <= 4'h0;
         core_rst_q <= 1'b0;
      end else if (clk_en) begin
         if (!rst_pin) begin
            rst_cnt_q <= 4'h0;
            core_rst_q <= 1'b0;
         end else if (rst_cnt_q == 4'(`RESET_CLKS - 1)) begin
            core_rst_q <= 1'b1;
         end else begin
            rst_cnt_q <= rst_cnt_q + 4'h1;
         end
      end
   end

   // control register; pin reset also reloads its reset value
   always_ff @(posedge ref_clk) begin
      if (soft_rst) begin
         ctrl_q <= `CTRL_RESET;
      end else if (clk_en && reg_wr && reg_addr == `REG_CTRL) begin
         ctrl_q <= reg_wdata & `CTRL_MASK;
      end
   end

   // register read data, one cycle after the strobe only
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         reg_rdata <= 8'h00;
      end else if (clk_en) begin
         reg_rdata <= 8'h00;
         if (reg_rd && reg_addr == `REG_CTRL) begin
            reg_rdata <= ctrl_q;
         end else if (reg_rd && reg_addr == `REG_STAT) begin
            reg_rdata <= {4'h0, local_q, core_rst_q, ext_code_select_n,
                          state_q != ST_IDLE};
         end
      end
   end

   // bus sequencer; requests start on a machine cycle boundary
   always_ff @(posedge ref_clk) begin
      if (soft_rst) begin
         state_q <= ST_IDLE;
         cur_q <= '0;
         cnt_q <= 6'h0;
         local_q <= 1'b0;
         ack_q <= 1'b0;
         rdata_q <= 8'h00;
      end else if (clk_en) begin
         ack_q <= 1'b0;
         case (state_q)
            ST_IDLE: begin
               if (req_valid && mc_end && !ack_q) begin
                  cur_q <= req;
                  local_q <= is_local(req, ext_code_select_n,
                                      ctrl_q[`CTRL_SRAM_ON_BIT]);
                  if (is_local(req, ext_code_select_n,
                               ctrl_q[`CTRL_SRAM_ON_BIT])) begin
                     ack_q <= 1'b1; // on chip: no bus cycle
                  end else begin
                     state_q <= ST_ADDR;
                     cnt_q <= 6'(`ADDR_CLKS - 1);
                  end
               end
            end
            ST_ADDR: begin
               if (cnt_q == 6'h0) begin
                  state_q <= ST_STRB;
                  cnt_q <= strb_clks(cur_q.kind,
                     ctrl_q[`CTRL_STRETCH_LSB +: `CTRL_STRETCH_W]) - 6'h1;
               end else begin
                  cnt_q <= cnt_q - 6'h1;
               end
            end
            ST_STRB: begin
               if (cnt_q != 6'h0) begin
                  cnt_q <= cnt_q - 6'h1;
               end else if (!(wait_hold && !is_code)) begin
                  state_q <= ST_IDLE;
                  ack_q <= 1'b1;
                  rdata_q <= p0_in; // sampled as the strobe rises
               end
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   // ale, program store, write and read strobes; all registered for clean edges
   always_ff @(posedge ref_clk) begin
      if (soft_rst) begin
         ale_q <= 1'b0;
         program_store_strobe_n_n_q <= 1'b1;
         wr_n_q <= 1'b1;
         rd_n_q <= 1'b1;
      end else if (clk_en) begin
         // ale high through the address phase only
         ale_q <= (state_q == ST_IDLE && req_valid && mc_end && !ack_q &&
                   !is_local(req, ext_code_select_n,
                             ctrl_q[`CTRL_SRAM_ON_BIT])) ||
                  (state_q == ST_ADDR && cnt_q != 6'h0);
         program_store_strobe_n_n_q <= !((state_q == ST_ADDR && cnt_q == 6'h0 && is_code) ||
                       (state_q == ST_STRB && cnt_q != 6'h0 && is_code));
         wr_n_q <= !((state_q == ST_ADDR && cnt_q == 6'h0 &&
                      cur_q.kind == ACC_DWR) ||
                     (state_q == ST_STRB && cur_q.kind == ACC_DWR &&
                      (cnt_q != 6'h0 || wait_hold)));
         rd_n_q <= !((state_q == ST_ADDR && cnt_q == 6'h0 &&
                      cur_q.kind == ACC_DRD) ||
                     (state_q == ST_STRB && cur_q.kind == ACC_DRD &&
                      (cnt_q != 6'h0 || wait_hold)));
      end
   end

   // port drive: bus owns ports 0/2 while an external access runs
   always_ff @(posedge ref_clk) begin
      if (soft_rst) begin
         p0_out_q <= 8'h00;
         p0_oe_q <= 8'h00;
         p2_out_q <= 8'hff;
         p2_oe_q <= 8'h00;
      end else if (clk_en) begin
         if (ale_q || state_q == ST_ADDR) begin
            p0_out_q <= cur_q.addr[7:0]; // low address
            p0_oe_q <= 8'hff;
            p2_out_q <= cur_q.addr[15:8]; // upper address
            p2_oe_q <= 8'hff;
         end else if (state_q == ST_STRB) begin
            p0_out_q <= cur_q.wdata;
            p0_oe_q <= {8{cur_q.kind == ACC_DWR}}; // read: rom/ram drives
            p2_out_q <= cur_q.addr[15:8];
            p2_oe_q <= 8'hff;
         end else begin
            // open drain: only a zero is driven
            p0_out_q <= 8'h00;
            p0_oe_q <= ~p0_latch;
            // quasi port: drive low, pull-up gives high
            p2_out_q <= p2_latch;
            p2_oe_q <= ~p2_latch;
         end
      end
   end

   // ports 1, 3, 4 with alternate functions
   always_ff @(posedge ref_clk) begin
      if (soft_rst) begin
         p1_out_q <= 8'hff;
         p1_oe_q <= 8'h00;
         p3_out_q <= 8'hff;
         p3_oe_q <= 8'h00;
         p4_out_q <= 4'hf;
         p4_oe_q <= 4'h0;
      end else if (clk_en) begin
         p1_out_q <= {p1_latch[7:4], p1_latch[3] & uart1_tx,
                      p1_latch[2:0]};
         p1_oe_q <= ~{p1_latch[7:4], p1_latch[3] & uart1_tx, p1_latch[2:0]};
         p3_out_q <= {p3_latch[7] & rd_n_q, p3_latch[6] & wr_n_q,
                      p3_latch[5:2], p3_latch[1] & uart0_tx,
                      p3_latch[0]};
         p3_oe_q <= ~{p3_latch[7] & rd_n_q, p3_latch[6] & wr_n_q,
                      p3_latch[5:2], p3_latch[1] & uart0_tx, p3_latch[0]};
         p4_out_q <= p4_latch;
         p4_oe_q <= {~p4_latch[3:1], ~p4_latch[0] & !wait_en};
      end
   end

   // alternate inputs taken from the pins
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         alt_q <= '1;
      end else if (clk_en) begin
         alt_q <= {p1_in[0], p1_in[1], p1_in[2], p1_in[7:4],
                   p3_in[0], p3_in[2], p3_in[3], p3_in[4],
                   p3_in[5]};
      end
   end

   assign ack = ack_q;
   assign ack_local = local_q;
   assign ack_rdata = rdata_q;
   // idle is the only state with bit 0 low, so busy is a bare flop bit
   assign busy = state_q[0];
   assign core_rst = core_rst_q;
   assign ale = ale_q;
   assign program_store_strobe_n = program_store_strobe_n_n_q;
   assign p0_out = p0_out_q;
   assign p0_oe = p0_oe_q;
   assign p1_out = p1_out_q;
   assign p1_oe = p1_oe_q;
   assign p2_out = p2_out_q;
   assign p2_oe = p2_oe_q;
   assign p3_out = p3_out_q;
   assign p3_oe = p3_oe_q;
   assign p4_out = p4_out_q;
   assign p4_oe = p4_oe_q;
   assign alt_in = alt_q;

   // checks on the sequencer and pins
   sequence s_ext_start;
      state_q == ST_IDLE ##1 state_q == ST_ADDR;
   endsequence
   sequence s_addr_phase;
      ale [*2] ##1 !ale;
   endsequence

   AST_EA_LOW_EXTERNAL: assert property (@(posedge ref_clk)
      disable iff (!nrst) ack && !ext_code_select_n &&
      cur_q.kind == ACC_FETCH |-> !ack_local)
      else $error("fetch stayed internal with ea low");
   AST_LOCAL_NO_ALE: assert property (@(posedge ref_clk)
      disable iff (!nrst) ack && ack_local |-> !ale && $past(!ale))
      else $error("bus cycle for an on-chip access");
   AST_PROGRAM_STORE_STROBE_N_CODE_ONLY: assert property (@(posedge ref_clk)
      disable iff (!nrst) !program_store_strobe_n |-> is_code && busy)
      else $error("program strobe outside a code access");
   AST_ALE_TWO_CLKS: assert property (@(posedge ref_clk)
      disable iff (!nrst) clk_en [*4] ##0 s_ext_start |-> s_addr_phase)
      else $error("address latch strobe not two clocks");
   AST_PIN_RESET: assert property (@(posedge ref_clk)
      disable iff (!nrst) (rst_pin && clk_en) [*8] |=> core_rst)
      else $error("reset pin held two cycles but no reset");
   AST_PHASE_WRAP: assert property (@(posedge ref_clk)
      disable iff (!nrst) clk_en && phase_q == 2'h3 |=> phase_q == 2'h0)
      else $error("machine cycle not four clocks");
   AST_STRB_EXCLUSIVE: assert property (@(posedge ref_clk)
      disable iff (!nrst) !(!p3_out[`P3_WR_BIT] && !p3_out[`P3_RD_BIT]
      && p3_latch[`P3_WR_BIT] && p3_latch[`P3_RD_BIT]))
      else $error("read and write strobes together");
   AST_WAIT_INPUT_ONLY: assert property (@(posedge ref_clk)
      disable iff (!nrst) clk_en && wait_en |=> !p4_oe[0])
      else $error("wait pin driven while enabled");
   AST_SRAM_OFF_RESET: assert property (@(posedge ref_clk)
      disable iff (!nrst) $rose(core_rst) |=> !ctrl_q[`CTRL_SRAM_ON_BIT])
      else $error("sram left on after reset");
   AST_WAIT_STRETCH: assert property (@(posedge ref_clk)
      disable iff (!nrst) clk_en && state_q == ST_STRB && cnt_q == 6'h0 &&
      !is_code && wait_hold |=> state_q == ST_STRB)
      else $error("access ended while wait asserted");

endmodule : ext_bus_unit

// file: ext_mem_model.sv
// behavioural external rom, data ram and slow-device wait source
`timescale 1ns/1ps
module ext_mem_model (
   // clock
   input wire logic ref_clk,
   // bus pins from the unit
   input wire logic ale,
   input wire logic program_store_strobe_n,
   input wire logic [7:0] p0_out,
   input wire logic [7:0] p0_oe,
   input wire logic [7:0] p2_out,
   input wire logic rd_n,
   input wire logic wr_n,
   // strobe cycles for which the device asks to wait
   input wire logic [3:0] wait_len,
   // pins back to the unit
   output logic [7:0] p0_in,
   output logic wait_n,
   output logic [15:0] addr_seen
);
   logic [7:0] ram [0:255]; // data store, decoded on the low byte only
   logic [7:0] lo_q; // external address latch
   logic [7:0] last_q; // last level seen on port 0
   logic [3:0] cnt_q; // strobe cycles so far
   logic strb; // any data strobe low
   logic [7:0] drv; // what the memory puts on port 0
   assign strb = !rd_n || !wr_n;
   // the latch follows port 0 only while ale is high, so the data
   // phase that follows never disturbs the held address
   always_ff @(posedge ref_clk) begin
      if (ale) lo_q <= p0_out;
      if (strb || !program_store_strobe_n) addr_seen <= {p2_out, lo_q};
      if (!wr_n) ram[lo_q] <= p0_out;
      last_q <= p0_in;
      cnt_q <= strb ? cnt_q + 4'h1 : 4'h0;
   end
   // rom answers on the program strobe, ram on the read strobe
   assign drv = !program_store_strobe_n ? (lo_q ^ p2_out) : ram[lo_q];
   // no pull-up on port 0: a released bus shows the inverse, not a hold
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         if (p0_oe[i]) p0_in[i] = p0_out[i];
         else if (!program_store_strobe_n || !rd_n) p0_in[i] = drv[i];
         else p0_in[i] = ~last_q[i];
      end
   end
   // slow device holds wait low for the first wait_len strobe cycles
   assign wait_n = !(strb && cnt_q < wait_len);
endmodule : ext_mem_model

// file: ext_bus_unit_tb_top.sv
// self-checking bench for the external bus unit
`timescale 1ns/1ps
`include "ext_bus_params.svh"
module ext_bus_unit_tb_top
   import ext_bus_pkg::*;
;
   logic ref_clk = 1'b0; // bench clock
   logic nrst = 1'b0; // synchronous reset, low active
   logic clk_en = 1'b1;
   logic [3:0] reg_addr = 4'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic req_valid = 1'b0;
   acc_req_t req = '0;
   logic [7:0] latch_v = 8'hff; // core port latches left high
   logic [7:0] p1_in = 8'h00;
   logic [7:0] p3_in = 8'hff;
   logic uart0_tx = 1'b1, uart1_tx = 1'b1, ea_n = 1'b1, rst_pin = 1'b0;
   logic [3:0] wait_len = 4'h0; // model wait request length
   logic [7:0] reg_rdata, ack_rdata, p0_in, p0_out, p0_oe, p1_out, p1_oe;
   logic [7:0] p2_out, p2_oe, p3_out, p3_oe;
   logic [3:0] p4_out, p4_oe;
   logic ack, ack_local, busy, core_rst, ale, program_store_strobe_n;
   logic wait_n;
   logic [15:0] addr_seen;
   alt_in_t alt_in;
   int n_mismatch = 0;
   int samples_checked = 0;
   int n_busy = 0; // busy cycles seen during the last access
   // free-running clock
   always #(`CLK_PERIOD_NS / 2.0) ref_clk = ~ref_clk;
   ext_bus_unit dut_u (.ref_clk(ref_clk), .nrst(nrst), .clk_en(clk_en),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .req_valid(req_valid),
      .req(req), .ack(ack), .ack_local(ack_local), .ack_rdata(ack_rdata),
      .busy(busy), .p0_latch(latch_v), .p1_latch(latch_v),
      .p2_latch(latch_v), .p3_latch(latch_v), .p4_latch(latch_v[3:0]),
      .uart0_tx(uart0_tx), .uart1_tx(uart1_tx), .core_rst(core_rst),
      .ext_code_select_n(ea_n), .rst_pin(rst_pin), .ale(ale),
      .program_store_strobe_n(program_store_strobe_n), .p0_in(p0_in),
      .p0_out(p0_out), .p0_oe(p0_oe), .p1_in(p1_in), .p1_out(p1_out),
      .p1_oe(p1_oe), .p2_out(p2_out), .p2_oe(p2_oe), .p3_in(p3_in),
      .p3_out(p3_out), .p3_oe(p3_oe), .p4_in({3'h7, wait_n}),
      .p4_out(p4_out), .p4_oe(p4_oe), .alt_in(alt_in));
   ext_mem_model mem_u (.ref_clk(ref_clk), .ale(ale),
      .program_store_strobe_n(program_store_strobe_n), .p0_out(p0_out),
      .p0_oe(p0_oe), .p2_out(p2_out), .rd_n(p3_out[`P3_RD_BIT]),
      .wr_n(p3_out[`P3_WR_BIT]), .wait_len(wait_len), .p0_in(p0_in),
      .wait_n(wait_n), .addr_seen(addr_seen));
   // one comparison, counted, reported at once on a mismatch
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   // register write, one strobe cycle
   task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask : reg_write
   // register read, data taken in the cycle after the strobe
   task automatic reg_read(input logic [3:0] a, output logic [7:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      @(negedge ref_clk);
      d = reg_rdata;
   endtask : reg_read
   // one core access held until ack; slen counts strobe-low cycles
   task automatic acc(input acc_kind_t k, input logic [15:0] a,
         input logic [7:0] wd, output logic [7:0] rd, output logic loc,
         output int slen);
      slen = 0;
      n_busy = 0;
      @(posedge ref_clk);
      req_valid <= 1'b1;
      req <= {k, a, wd};
      for (int i = 0; i < 400; i++) begin
         @(negedge ref_clk);
         if (!(p3_out[7] & p3_out[6] & program_store_strobe_n)) slen++;
         if (busy === 1'b1) n_busy++;
         if (ack === 1'b1) break;
      end
      // a missing acknowledge is a failure, not a silent return
      if (ack !== 1'b1) begin
         n_mismatch++;
         $display("ERROR %0t: access never acknowledged", $time);
      end
      rd = ack_rdata;
      loc = ack_local;
      @(posedge ref_clk);
      req_valid <= 1'b0;
   endtask : acc
   // idle pin levels and register defaults straight after reset
   task automatic t_reset();
      logic [7:0] d;
      @(negedge ref_clk);
      check({ale, program_store_strobe_n}, 2'h1);
      check(p0_oe, 8'h00);
      check({p2_out, p2_oe}, 16'hff00);
      check({p3_out[7:6], p4_oe[0]}, 3'h6);
      check({p1_oe, p3_oe}, 16'h0000);
      check(p4_out, 4'hf);
      reg_read(`REG_CTRL, d);
      check(d, `CTRL_RESET);
      reg_read(4'hf, d);
      check(d, 8'h00);
   endtask : t_reset
   // internal and external fetches around the 32 KB boundary
   task automatic t_fetch();
      logic [15:0] tbl [0:3] = '{16'h7fff, 16'h8123, 16'h0042, 16'h9001};
      logic [7:0] d;
      logic loc;
      int n;
      for (int i = 0; i < 4; i++) begin
         @(posedge ref_clk);
         ea_n <= (i != 2);
         acc(i == 3 ? ACC_MOVC : ACC_FETCH, tbl[i], 8'h00, d, loc, n);
         check(loc, i == 0);
         check(n > 0, i != 0);
         check(n_busy > 0, i != 0);
         if (i != 0) begin
            check(d, tbl[i][15:8] ^ tbl[i][7:0]);
            check(addr_seen, tbl[i]);
         end
      end
      ea_n <= 1'b1;
   endtask : t_fetch
   // data write/read, stretch range and the on-chip sram window
   task automatic t_data();
      logic [7:0] d;
      logic loc;
      int n0, n7;
      acc(ACC_DWR, 16'h0020, 8'h3c, d, loc, n0);
      check({loc, addr_seen}, 17'h00020);
      reg_write(`REG_CTRL, 8'h00);
      acc(ACC_DRD, 16'h0020, 8'h00, d, loc, n0);
      check(d, 8'h3c);
      reg_write(`REG_CTRL, 8'h07);
      acc(ACC_DRD, 16'h0020, 8'h00, d, loc, n7);
      check(n7 - n0, 7 * `MC_CLKS);
      reg_write(`REG_CTRL, 8'h11);
      acc(ACC_DRD, 16'h0020, 8'h00, d, loc, n0);
      check(loc, 1'b1);
      acc(ACC_DRD, `SRAM_TOP, 8'h00, d, loc, n0);
      check(loc, 1'b0);
   endtask : t_data
   // wait input ignored when disabled, stretches the strobe when enabled
   task automatic t_wait();
      logic [7:0] d;
      logic loc;
      int nb, na, nw;
      reg_write(`REG_CTRL, 8'h00);
      acc(ACC_DRD, 16'h0020, 8'h00, d, loc, nb);
      wait_len <= 4'hf;
      acc(ACC_DRD, 16'h0020, 8'h00, d, loc, na);
      check(na, nb);
      reg_write(`REG_CTRL, 8'h08);
      acc(ACC_DRD, 16'h0020, 8'h00, d, loc, nw);
      check({nw > na, d}, 9'h13c);
      // latch now asks to drive bit 0 low; wait enable must block it
      latch_v <= 8'hfe;
      repeat (2) @(posedge ref_clk);
      @(negedge ref_clk);
      check(p4_oe[0], 1'b0);
      reg_write(`REG_CTRL, 8'h00);
      repeat (2) @(posedge ref_clk);
      @(negedge ref_clk);
      check({p4_oe[0], p4_out[0]}, 2'h2);
      @(posedge ref_clk);
      latch_v <= 8'hff;
      wait_len <= 4'h0;
   endtask : t_wait
   // alternate inputs and serial outputs on ports 1 and 3
   task automatic t_alt();
      for (int i = 0; i < 2; i++) begin
         @(posedge ref_clk);
         p1_in <= i ? 8'h5a : 8'ha5;
         p3_in <= i ? 8'hc3 : 8'hfc;
         uart0_tx <= i[0];
         uart1_tx <= !i[0];
         repeat (4) @(posedge ref_clk);
         @(negedge ref_clk);
         check(alt_in, {p1_in[0], p1_in[1], p1_in[2], p1_in[7:4],
            p3_in[0], p3_in[2], p3_in[3], p3_in[4], p3_in[5]});
         check({p3_out[1], p1_out[3]}, {uart0_tx, uart1_tx});
      end
      // clock enable low freezes the input copies
      @(posedge ref_clk);
      clk_en <= 1'b0;
      p1_in <= 8'hff;
      repeat (3) @(posedge ref_clk);
      @(negedge ref_clk);
      check(alt_in.timer2_count_in, 1'b0);
      @(posedge ref_clk);
      clk_en <= 1'b1;
   endtask : t_alt
   // reset pin: one clock short does nothing, full length resets ctrl
   task automatic t_rst();
      logic [7:0] d;
      reg_write(`REG_CTRL, 8'h1b);
      @(posedge ref_clk);
      rst_pin <= 1'b1;
      repeat (`RESET_CLKS - 1) @(posedge ref_clk);
      rst_pin <= 1'b0;
      repeat (4) @(negedge ref_clk) check(core_rst, 1'b0);
      @(posedge ref_clk);
      rst_pin <= 1'b1;
      repeat (`RESET_CLKS + 2) @(posedge ref_clk);
      @(negedge ref_clk);
      check(core_rst, 1'b1);
      @(posedge ref_clk);
      rst_pin <= 1'b0;
      repeat (6) @(posedge ref_clk);
      reg_read(`REG_CTRL, d);
      check(d, `CTRL_RESET);
   endtask : t_rst
   // counts, verdict and end of run
   task automatic final_report();
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : final_report
   // main sequence after 20 cycles of reset
   initial begin
      repeat (20) @(posedge ref_clk);
      nrst <= 1'b1;
      t_reset();
      t_fetch();
      t_data();
      t_wait();
      t_alt();
      t_rst();
      final_report();
   end
   // watchdog, far beyond the few hundred cycles the tests need
   initial begin
      repeat (20000) @(posedge ref_clk);
      n_mismatch++;
      $display("ERROR %0t: watchdog expired", $time);
      final_report();
   end
endmodule : ext_bus_unit_tb_top
